// File: eac_pkg.sv
// eac_pkg: register map, field positions, timing counts and shared types of the
// eeprom access control block.
// assumes a 32-bit Avalon-MM slave with byte addresses and one aligned word per register.
package eac_pkg;

    // bus geometry
    localparam int unsigned AVS_AW = 5;
    localparam int unsigned AVS_DW = 32;

    // register byte offsets
    localparam logic [AVS_AW-1:0] OFS_CONTROL    = 5'h00;
    localparam logic [AVS_AW-1:0] OFS_ADDRESS    = 5'h04;
    localparam logic [AVS_AW-1:0] OFS_DATA       = 5'h08;
    localparam logic [AVS_AW-1:0] OFS_IRQ_STATUS = 5'h0C;
    localparam logic [AVS_AW-1:0] OFS_IRQ_CLEAR  = 5'h10;
    localparam logic [AVS_AW-1:0] OFS_IRQ_ENABLE = 5'h14;

    // nv_control_reg field positions
    localparam int unsigned CTL_READ_BIT  = 0;
    localparam int unsigned CTL_WRITE_BIT = 1;
    localparam int unsigned CTL_ARM_BIT   = 2;
    localparam int unsigned CTL_FLASH_BIT = 3;

    // interrupt event positions
    localparam int unsigned EV_W               = 3;
    localparam int unsigned EV_DONE_BIT        = 0;
    localparam int unsigned EV_ARM_TIMEOUT_BIT = 1;
    localparam int unsigned EV_REFUSED_BIT     = 2;

    // array geometry and reset values
    localparam int unsigned NV_ADDR_W   = 9;
    localparam int unsigned NV_DEPTH    = 512;
    localparam logic [8:0]  RST_ADDRESS = 9'h000;
    localparam logic [7:0]  RST_DATA    = 8'h00;
    localparam logic [2:0]  RST_EVENTS  = 3'h0;

    // timing in system clock cycles, and write duration in rc oscillator cycles
    localparam int unsigned ARM_WINDOW_CYCLES  = 4;
    localparam int unsigned WRITE_STALL_CYCLES = 2;
    localparam int unsigned READ_STALL_CYCLES  = 4;
    localparam int unsigned WRITE_RC_CYCLES    = 26368;
    localparam real         WRITE_TIME_MS      = 3.3; // typical only, not used for timing

    // bus handshake states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_STALL = 2'b01,
        ST_ACK   = 2'b10
    } eac_bus_state_e;

    // one bus request as seen at the slave
    typedef struct packed {
        logic              read;
        logic              write;
        logic [AVS_AW-1:0] address;
        logic [AVS_DW-1:0] writedata;
        logic [3:0]        byteenable;
    } eac_req_s;

    // address and byte latched for one array write
    typedef struct packed {
        logic [NV_ADDR_W-1:0] addr;
        logic [7:0]           data;
    } eac_job_s;

endpackage : eac_pkg

// File: eac_pin_sync.sv
// eac_pin_sync: two-flop synchroniser for one pin, with a rising-edge pulse.
// assumes the pin is asynchronous to sys_clk and slower than half its rate.
`timescale 1ns/1ns
`default_nettype none
module eac_pin_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // pin side
    input  wire logic pin_async,
    // synchronised side
    output var  logic level,
    output var  logic rise
);
    logic meta_r;
    logic hold_r;

    // meta_r feeds only level; edge detect looks at the settled copies
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            level  <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            meta_r <= pin_async;
            level  <= meta_r;
            hold_r <= level;
        end
    end

    // one pulse per low-to-high transition of the pin
    always_comb begin
        rise = level & ~hold_r;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_rise_delay;
        rise |-> $past(pin_async, 2) && !$past(pin_async, 3);
    endproperty
    a_rise_delay: assert property (p_rise_delay) else $error("edge pulse without a pin edge");

endmodule : eac_pin_sync
`default_nettype wire

// File: eac_write_timer.sv
// eac_write_timer: times one array write in rc oscillator ticks.
// assumes tick is a one-cycle pulse on sys_clk, one per rc oscillator period.
`timescale 1ns/1ns
`default_nettype none
module eac_write_timer #(
    parameter int unsigned CYCLES = eac_pkg::WRITE_RC_CYCLES
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // control
    input  wire logic start,
    input  wire logic tick,
    // status
    output var  logic running,
    output var  logic done
);
    localparam int unsigned CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] cnt_r;

    if (CYCLES < 2) begin : g_bad_cycles
        $error("write timer needs at least two ticks");
    end

    // counts only on rc ticks, so the duration does not follow sys_clk
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            running <= 1'b0;
            done    <= 1'b0;
            cnt_r   <= '0;
        end else begin
            done <= 1'b0;
            if (!running) begin
                if (start) begin
                    running <= 1'b1;
                    cnt_r   <= '0;
                end
            end else if (tick) begin
                if (cnt_r == LAST) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_done_at_last;
        done |-> $past(running) && $past(tick) && ($past(cnt_r) == LAST);
    endproperty
    a_done_at_last: assert property (p_done_at_last) else $error("write ended early");

    property p_count_on_tick;
        running && $past(running) && !$past(tick) |-> $stable(cnt_r);
    endproperty
    a_count_on_tick: assert property (p_count_on_tick) else $error("count moved without tick");

endmodule : eac_write_timer
`default_nettype wire

// File: eac_eeprom_access_control.sv
// eac_eeprom_access_control: cpu access control for a byte-wide nonvolatile array,
// reached as an Avalon-MM slave with waitrequest; holds the array itself.
// assumes rc_osc_tick and flash_selfprog_active are pins from outside sys_clk.
`timescale 1ns/1ns
`default_nettype none
module eac_eeprom_access_control #(
    parameter int unsigned DEPTH        = eac_pkg::NV_DEPTH,
    parameter int unsigned ARM_WINDOW   = eac_pkg::ARM_WINDOW_CYCLES,
    parameter int unsigned WRITE_CYCLES = eac_pkg::WRITE_RC_CYCLES
) (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    // avalon-mm slave
    input  wire logic [eac_pkg::AVS_AW-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [eac_pkg::AVS_DW-1:0] avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output var  logic [eac_pkg::AVS_DW-1:0] avs_readdata,
    output var  logic                      avs_waitrequest,
    // pins
    input  wire logic                      rc_osc_tick,
    input  wire logic                      flash_selfprog_active,
    // interrupt
    output var  logic                      irq
);
    localparam int unsigned ADDR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || DEPTH > eac_pkg::NV_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("depth must be a power of two up to the array limit");
    end
    if (ARM_WINDOW < 1 || ARM_WINDOW > 7) begin : g_bad_window
        $error("arm window must be 1 to 7 cycles");
    end

    // address decode used by several processes
    function automatic logic eac_hit(input logic [eac_pkg::AVS_AW-1:0] a,
                                     input logic [eac_pkg::AVS_AW-1:0] ofs);
        eac_hit = (a == ofs);
    endfunction : eac_hit

    eac_pkg::eac_req_s       req;
    eac_pkg::eac_bus_state_e state_r;
    eac_pkg::eac_job_s       job_r;
    logic [2:0]              stall_cnt_r;
    logic [2:0]              arm_cnt_r;
    logic                    master_write_arm_r;
    logic                    arm_used_r;
    logic [eac_pkg::NV_ADDR_W-1:0] nv_address_reg_r;
    logic [7:0]              nv_data_reg_r;
    logic [eac_pkg::EV_W-1:0] irq_status_r;
    logic [eac_pkg::EV_W-1:0] irq_enable_r;
    logic [eac_pkg::EV_W-1:0] ev;
    logic [eac_pkg::EV_W-1:0] clr;
    logic [7:0]              mem_r [DEPTH];
    logic [7:0]              rd_byte;
    logic [eac_pkg::AVS_DW-1:0] rd_mux;
    logic take, wr_take, rd_take, ctl_wr, strobe_wr, arm_wr, read_wr;
    logic write_start, read_go, strobe_refused, arm_timeout;
    logic rc_tick, flash_level, write_strobe_busy, wt_done;

    // gather the bus signals into one request
    assign req = '{read: avs_read, write: avs_write, address: avs_address,
                   writedata: avs_writedata, byteenable: avs_byteenable};

    // pin synchronisers
    eac_pin_sync u_rc_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pin_async (rc_osc_tick),
        .level     (),
        .rise      (rc_tick)
    );
    eac_pin_sync u_flash_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .pin_async (flash_selfprog_active),
        .level     (flash_level),
        .rise      ()
    );

    // write duration counter
    eac_write_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (write_start),
        .tick    (rc_tick),
        .running (write_strobe_busy),
        .done    (wt_done)
    );

    // request decode; every effect is taken once, when the request is first seen
    always_comb begin
        take        = (state_r == eac_pkg::ST_IDLE) && (req.read || req.write);
        wr_take     = take && req.write;
        rd_take     = take && req.read && !req.write;
        ctl_wr      = wr_take && eac_hit(req.address, eac_pkg::OFS_CONTROL) && req.byteenable[0];
        strobe_wr   = ctl_wr && req.writedata[eac_pkg::CTL_WRITE_BIT];
        arm_wr      = ctl_wr && req.writedata[eac_pkg::CTL_ARM_BIT];
        read_wr     = ctl_wr && req.writedata[eac_pkg::CTL_READ_BIT];
        // arm must already stand; arming and strobing in one write does not count
        write_start = strobe_wr && master_write_arm_r && !write_strobe_busy
                      && !flash_level;
        read_go     = read_wr && !write_strobe_busy;
        strobe_refused = (strobe_wr && !write_start) || (read_wr && !read_go);
        arm_timeout = master_write_arm_r && (arm_cnt_r == 3'h0) && !arm_used_r && !arm_wr;
    end

    // array read port, low address bits only when the depth is smaller
    assign rd_byte = mem_r[nv_address_reg_r[ADDR_W-1:0]];

    // bus handshake: waitrequest stays high except for the one answer cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r         <= eac_pkg::ST_IDLE;
            stall_cnt_r     <= 3'h0;
            avs_waitrequest <= 1'b1;
        end else begin
            unique case (state_r)
                eac_pkg::ST_IDLE: begin
                    if (read_go) begin
                        state_r     <= eac_pkg::ST_STALL;
                        stall_cnt_r <= 3'(eac_pkg::READ_STALL_CYCLES - 1);
                    end else if (write_start) begin
                        state_r     <= eac_pkg::ST_STALL;
                        stall_cnt_r <= 3'(eac_pkg::WRITE_STALL_CYCLES - 1);
                    end else if (take) begin
                        state_r         <= eac_pkg::ST_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                eac_pkg::ST_STALL: begin
                    if (stall_cnt_r == 3'h0) begin
                        state_r         <= eac_pkg::ST_ACK;
                        avs_waitrequest <= 1'b0;
                    end else begin
                        stall_cnt_r <= stall_cnt_r - 3'h1;
                    end
                end
                eac_pkg::ST_ACK: begin
                    state_r         <= eac_pkg::ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    state_r         <= eac_pkg::ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // read data mux; reserved bits and unmapped offsets read as zero
    always_comb begin
        rd_mux = '0;
        if (eac_hit(req.address, eac_pkg::OFS_CONTROL)) begin
            rd_mux[eac_pkg::CTL_ARM_BIT]   = master_write_arm_r;
            rd_mux[eac_pkg::CTL_WRITE_BIT] = write_strobe_busy;
            rd_mux[eac_pkg::CTL_FLASH_BIT] = flash_level;
        end else if (eac_hit(req.address, eac_pkg::OFS_ADDRESS)) begin
            rd_mux[eac_pkg::NV_ADDR_W-1:0] = nv_address_reg_r;
        end else if (eac_hit(req.address, eac_pkg::OFS_DATA)) begin
            rd_mux[7:0] = nv_data_reg_r;
        end else if (eac_hit(req.address, eac_pkg::OFS_IRQ_STATUS)) begin
            rd_mux[eac_pkg::EV_W-1:0] = irq_status_r;
        end else if (eac_hit(req.address, eac_pkg::OFS_IRQ_ENABLE)) begin
            rd_mux[eac_pkg::EV_W-1:0] = irq_enable_r;
        end
    end

    // read data is captured at the take and held until the answer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (rd_take) begin
            avs_readdata <= rd_mux;
        end
    end

    // arming window: a fixed count, not consumed by the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            master_write_arm_r <= 1'b0;
            arm_cnt_r          <= 3'h0;
            arm_used_r         <= 1'b0;
        end else begin
            if (arm_wr) begin
                master_write_arm_r <= 1'b1;
                arm_cnt_r          <= 3'(ARM_WINDOW - 1);
                arm_used_r         <= 1'b0;
            end else if (master_write_arm_r) begin
                if (arm_cnt_r == 3'h0) begin
                    master_write_arm_r <= 1'b0;
                end else begin
                    arm_cnt_r <= arm_cnt_r - 3'h1;
                end
                if (write_start) begin
                    arm_used_r <= 1'b1;
                end
            end
        end
    end

    // address register, frozen while a write runs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nv_address_reg_r <= eac_pkg::RST_ADDRESS;
        end else if (wr_take && eac_hit(req.address, eac_pkg::OFS_ADDRESS)
                     && !write_strobe_busy) begin
            if (req.byteenable[0]) begin
                nv_address_reg_r[7:0] <= req.writedata[7:0];
            end
            if (req.byteenable[1]) begin
                nv_address_reg_r[8] <= req.writedata[8];
            end
        end
    end

    // data register: cpu writes, or array read on the read strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nv_data_reg_r <= eac_pkg::RST_DATA;
        end else if (read_go) begin
            nv_data_reg_r <= rd_byte;
        end else if (wr_take && eac_hit(req.address, eac_pkg::OFS_DATA) && req.byteenable[0]) begin
            nv_data_reg_r <= req.writedata[7:0];
        end
    end

    // latch the job so later register writes cannot disturb a running write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            job_r <= '0;
        end else if (write_start) begin
            job_r <= '{addr: nv_address_reg_r, data: nv_data_reg_r};
        end
    end

    // array update at the end of the timed write; array content has no reset
    always_ff @(posedge sys_clk) begin
        if (wt_done) begin
            mem_r[job_r.addr[ADDR_W-1:0]] <= job_r.data;
        end
    end

    // interrupt events and software clear
    always_comb begin
        ev = '0;
        ev[eac_pkg::EV_DONE_BIT]        = wt_done;
        ev[eac_pkg::EV_ARM_TIMEOUT_BIT] = arm_timeout;
        ev[eac_pkg::EV_REFUSED_BIT]     = strobe_refused;
        clr = '0;
        if (wr_take && eac_hit(req.address, eac_pkg::OFS_IRQ_CLEAR) && req.byteenable[0]) begin
            clr = req.writedata[eac_pkg::EV_W-1:0];
        end
    end

    // sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_status_r <= eac_pkg::RST_EVENTS;
            irq_enable_r <= eac_pkg::RST_EVENTS;
            irq          <= 1'b0;
        end else begin
            irq_status_r <= (irq_status_r & ~clr) | ev;
            if (wr_take && eac_hit(req.address, eac_pkg::OFS_IRQ_ENABLE) && req.byteenable[0]) begin
                irq_enable_r <= req.writedata[eac_pkg::EV_W-1:0];
            end
            irq <= |(irq_status_r & irq_enable_r);
        end
    end

    // helper for checks: cycles since the last arming write, saturating
    logic [2:0] arm_age_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            arm_age_r <= 3'h7;
        end else if (arm_wr) begin
            arm_age_r <= 3'h1;
        end else if (arm_age_r != 3'h7) begin
            arm_age_r <= arm_age_r + 3'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_arm_window;
        master_write_arm_r == ((arm_age_r >= 3'h1) && (arm_age_r <= 3'(ARM_WINDOW)));
    endproperty
    a_arm_window: assert property (p_arm_window) else $error("arm window length wrong");

    property p_start_needs_arm;
        $rose(write_strobe_busy) |-> $past(master_write_arm_r) && $past(strobe_wr);
    endproperty
    a_start_needs_arm: assert property (p_start_needs_arm) else $error("write without arm");

    property p_unarmed_ignored;
        strobe_wr && !master_write_arm_r |=> !$rose(write_strobe_busy);
    endproperty
    a_unarmed_ignored: assert property (p_unarmed_ignored) else $error("unarmed strobe wrote");

    property p_flash_blocks;
        strobe_wr && flash_level |=> !$rose(write_strobe_busy);
    endproperty
    a_flash_blocks: assert property (p_flash_blocks) else $error("write during flash program");

    property p_busy_until_done;
        write_strobe_busy && !wt_done |=> write_strobe_busy || wt_done;
    endproperty
    a_busy_until_done: assert property (p_busy_until_done) else $error("busy dropped early");

    property p_write_stall;
        write_start && !read_go |=> (state_r == eac_pkg::ST_STALL) [*2] ##1 !avs_waitrequest;
    endproperty
    a_write_stall: assert property (p_write_stall) else $error("write stall not two cycles");

    property p_read_data;
        read_go |=> nv_data_reg_r == $past(rd_byte);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not loaded");

    property p_read_stall;
        read_go |=> (state_r == eac_pkg::ST_STALL) [*4] ##1 !avs_waitrequest;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

    property p_busy_addr_frozen;
        write_strobe_busy |=> $stable(nv_address_reg_r);
    endproperty
    a_busy_addr_frozen: assert property (p_busy_addr_frozen) else $error("address moved in write");

    property p_busy_read_refused;
        read_wr && write_strobe_busy |=> $stable(nv_data_reg_r) && irq_status_r[2];
    endproperty
    a_busy_read_refused: assert property (p_busy_read_refused) else $error("read during write");

    property p_job_stable;
        write_strobe_busy && $past(write_strobe_busy) |-> $stable(job_r);
    endproperty
    a_job_stable: assert property (p_job_stable) else $error("job changed during write");

    property p_set_beats_clear;
        wt_done |=> irq_status_r[0];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("done event lost");

    c_write_done:  cover property (wt_done);
    c_read_go:     cover property (read_go);
    c_arm_timeout: cover property (arm_timeout);
    c_refused:     cover property (strobe_wr && !write_start);

endmodule : eac_eeprom_access_control
`default_nettype wire

// File: eac_far_side.sv
// eac_far_side: pins around the block, rc oscillator and flash self-programming flag.
// assumes the bench commands the flash flag; the rc clock runs free, unrelated to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module eac_far_side (
    // command from bench
    input  wire logic flash_req,
    // pins
    output var  logic rc_osc_tick,
    output var  logic flash_selfprog_active
);
    // about 7.8 MHz; a half period of 64 ns never lands on a sys_clk rising edge,
    // so the synchroniser and its checks never race the pin
    initial begin
        rc_osc_tick = 1'b0;
        forever #64 rc_osc_tick = ~rc_osc_tick;
    end
    // flash busy level as the core would show it
    always_comb flash_selfprog_active = flash_req;
endmodule : eac_far_side
`default_nettype wire

// File: eac_eeprom_access_control_bench.sv
// eac_eeprom_access_control_bench: register-level tests of the access control block.
// assumes eac_pkg is compiled first; write time shortened to 8 rc ticks.
`timescale 1ns/1ns
`default_nettype none
module eac_eeprom_access_control_bench;
    logic        sys_clk = 1'b0;
    logic        rst_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rc_osc_tick;
    logic        flash_selfprog_active;
    logic        flash_req;
    logic        irq;
    logic [31:0] q;
    int          n;
    int          cyc;
    int          err_total = 0;
    int          cmp_count = 0;

    eac_eeprom_access_control #(.WRITE_CYCLES(8)) eac_eeprom_access_control_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rc_osc_tick(rc_osc_tick), .flash_selfprog_active(flash_selfprog_active), .irq(irq));
    eac_far_side eac_far_side_i (.flash_req(flash_req), .rc_osc_tick(rc_osc_tick),
        .flash_selfprog_active(flash_selfprog_active));

    // 50 MHz
    always #10 sys_clk = ~sys_clk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // one request held until waitrequest is seen low; n counts edges, idle edge after;
    // only the watchdog ends a wait that never gets an answer
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        n = 0;
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        check(nm, q, e);
    endtask : rd

    // main sequence
    initial begin
        rst_n = 1'b0; avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; flash_req = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(eac_pkg::OFS_CONTROL, 32'h0, "ctl_reset");
        rd(eac_pkg::OFS_IRQ_STATUS, 32'h0, "status_reset");
        rd(5'h18, 32'h0, "unmapped");
        $display("test reset done");
        bus(1'b1, eac_pkg::OFS_IRQ_ENABLE, 32'h7);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h2);
        rd(eac_pkg::OFS_CONTROL, 32'h0, "unarmed_strobe");
        rd(eac_pkg::OFS_IRQ_STATUS, 32'h4, "refused_event");
        check("irq_refused", {31'h0, irq}, 32'h1);
        bus(1'b1, eac_pkg::OFS_IRQ_CLEAR, 32'h7);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h4);
        rd(eac_pkg::OFS_CONTROL, 32'h4, "arm_held");
        rd(eac_pkg::OFS_CONTROL, 32'h0, "arm_expired");
        rd(eac_pkg::OFS_IRQ_STATUS, 32'h2, "arm_timeout");
        bus(1'b1, eac_pkg::OFS_IRQ_CLEAR, 32'h7);
        $display("test arming done");
        // host order: idle, load address and data, arm, strobe; nothing comes between
        bus(1'b1, eac_pkg::OFS_ADDRESS, 32'h1FF);
        bus(1'b1, eac_pkg::OFS_DATA, 32'hA5);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h4);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h2);
        check("write_stall", n, 4);
        cyc = 3;
        rd(eac_pkg::OFS_CONTROL, 32'h2, "busy_set");
        bus(1'b1, eac_pkg::OFS_ADDRESS, 32'h000);
        bus(1'b1, eac_pkg::OFS_DATA, 32'h3C);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h1);
        rd(eac_pkg::OFS_ADDRESS, 32'h1FF, "addr_locked");
        rd(eac_pkg::OFS_DATA, 32'h3C, "read_refused");
        cyc = cyc + 18;
        // poll busy, three edges per read; the read strobe waits for busy to clear
        do begin
            bus(1'b0, eac_pkg::OFS_CONTROL, 32'h0);
            cyc = cyc + 3;
        end while (q[1] !== 1'b0 && cyc < 600);
        // eight ticks of 128 ns are about 51 cycles, plus sync and poll slack
        check("write_time", {31'h0, (cyc >= 40 && cyc <= 66)}, 32'h1);
        rd(eac_pkg::OFS_IRQ_STATUS, 32'h5, "done_event");
        check("irq_done", {31'h0, irq}, 32'h1);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h1);
        check("read_stall", n, 6);
        rd(eac_pkg::OFS_DATA, 32'hA5, "read_back");
        $display("test write and read done");
        bus(1'b1, eac_pkg::OFS_IRQ_ENABLE, 32'h0);
        bus(1'b1, eac_pkg::OFS_IRQ_CLEAR, 32'h7);
        flash_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h4);
        bus(1'b1, eac_pkg::OFS_CONTROL, 32'h2);
        rd(eac_pkg::OFS_CONTROL, 32'h8, "flash_blocks");
        // the refused strobe starts no write, so the arm window also times out
        rd(eac_pkg::OFS_IRQ_STATUS, 32'h6, "flash_refused");
        check("irq_masked", {31'h0, irq}, 32'h0);
        flash_req <= 1'b0;
        $display("test flash interlock done");
        complete_run();
    end

    // watchdog, tests need about 150 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
endmodule : eac_eeprom_access_control_bench
`default_nettype wire
